// ### rtl/sdc_host.sv
// sdram host controller: power-up sequence, command issue and clock gate
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defines.svh"
module sdc_host (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // user request
   input wire sdc_pkg::sdc_req_t req,
   input wire logic wake,
   output logic req_ready,
   output logic init_done,
   // sdram pins
   output sdc_pkg::sdc_pins_t pins
);
   import sdc_pkg::*;

   // ****************************************
   // state
   // ****************************************
   sdc_state_t st_r, st_nxt;
   logic [`SDC_CNT_W-1:0] cnt_r, cnt_nxt;
   logic [1:0] refs_r, refs_nxt;
   logic burst_r, burst_nxt;
   logic [3:0] open_r, open_nxt;
   sdc_req_t pend_r, pend_nxt;
   sdc_pins_t pins_r, pins_nxt;
   logic rdy_r, rdy_nxt;
   logic done_r, done_nxt;

   function automatic sdc_pins_t drive(input logic cke, input sdc_cmd_t c,
                                       input logic [1:0] ba, input logic [12:0] a, input logic [1:0] dm);
      sdc_pins_t p;
      p.cke = cke;
      {p.cs_n, p.ras_n, p.cas_n, p.we_n} = c;
      p.ba = ba;
      p.addr = a;
      p.dqm = dm;
      return p;
   endfunction : drive

   // banks left open after an access: auto precharge closes the addressed bank
   function automatic logic [3:0] after_access(input logic [3:0] o, input logic [1:0] ba, input logic ap);
      after_access = o & ~(ap ? (4'h1 << ba) : 4'h0);
   endfunction : after_access

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
      refs_nxt = refs_r;
      burst_nxt = burst_r;
      open_nxt = open_r;
      pend_nxt = pend_r;
      rdy_nxt = 1'b0;
      done_nxt = done_r;
      pins_nxt = drive(pins_r.cke, SDC_CMD_NOP, 2'h0, 13'h0_000, 2'h0);
      case (st_r)
         SDC_S_WAIT: begin
            // gate held low, raised mid-wait; only inhibits during the wait
            pins_nxt = drive(cnt_r <= `SDC_CNT_W'(`SDC_CKE_RAISE_CYC), SDC_CMD_INHIBIT,
                             2'h0, 13'h0_000, 2'h3);
            if (cnt_r == '0) begin
               pins_nxt = drive(1'b1, SDC_CMD_PRECHARGE, 2'h0, 13'h0_400, 2'h3);
               cnt_nxt = `SDC_CNT_W'(`SDC_TRP_CYC);
               st_nxt = SDC_S_PRE;
            end
         end
         SDC_S_PRE: if (cnt_r == '0) begin
            // bus released by the mode load itself (dqm high), both bank selects zero
            pins_nxt = drive(1'b1, SDC_CMD_MODE_LOAD, 2'h0, `SDC_MODE_VALUE, 2'h3);
            cnt_nxt = `SDC_CNT_W'(`SDC_MODE_LOAD_DELAY_CYC);
            st_nxt = SDC_S_MODE;
         end
         SDC_S_MODE: if (cnt_r == '0) begin
            pins_nxt = drive(1'b1, SDC_CMD_REFRESH, 2'h0, 13'h0_000, 2'h3);
            cnt_nxt = `SDC_CNT_W'(`SDC_REFRESH_CYCLE_TIME_CYC);
            refs_nxt = 2'd1;
            st_nxt = SDC_S_REF;
         end
         SDC_S_REF: if (cnt_r == '0) begin
            if (refs_r < 2'(`SDC_INIT_REFRESHES)) begin
               pins_nxt = drive(1'b1, SDC_CMD_REFRESH, 2'h0, 13'h0_000, 2'h3);
               cnt_nxt = `SDC_CNT_W'(`SDC_REFRESH_CYCLE_TIME_CYC);
               refs_nxt = refs_r + 2'd1;
            end else begin
               done_nxt = 1'b1;
               rdy_nxt = 1'b1;
               st_nxt = SDC_S_READY;
            end
         end
         SDC_S_GAP: begin
            // dqm held high ahead of a parked write; also the two no-ops after a power-down wake
            pins_nxt = drive(1'b1, SDC_CMD_NOP, 2'h0, 13'h0_000, 2'h3);
            if (cnt_r == '0) begin
               if (pend_r.valid) begin
                  pins_nxt = drive(1'b1, SDC_CMD_WRITE, pend_r.ba, pend_r.addr, 2'h0);
                  open_nxt = after_access(open_r, pend_r.ba, pend_r.addr[`SDC_A10_BIT]);
                  pend_nxt.valid = 1'b0;
                  burst_nxt = 1'b1;
               end
               rdy_nxt = 1'b1;
               st_nxt = SDC_S_READY;
            end
         end
         SDC_S_READY: begin
            rdy_nxt = 1'b1;
            if (req.valid) begin
               case (req.op)
                  SDC_OP_ACT: begin
                     pins_nxt = drive(1'b1, SDC_CMD_ACTIVATE, req.ba, req.addr, 2'h0);
                     open_nxt = open_r | (4'h1 << req.ba);
                  end
                  SDC_OP_READ: begin
                     pins_nxt = drive(1'b1, SDC_CMD_READ, req.ba, req.addr, 2'h0);
                     open_nxt = after_access(open_r, req.ba, req.addr[`SDC_A10_BIT]);
                     burst_nxt = 1'b1;
                  end
                  SDC_OP_WRITE: begin
                     // park the write behind two cycles of dqm so a read in flight never meets write data
                     pins_nxt = drive(1'b1, SDC_CMD_NOP, 2'h0, 13'h0_000, 2'h3);
                     pend_nxt = req;
                     cnt_nxt = `SDC_CNT_W'(1);
                     rdy_nxt = 1'b0;
                     st_nxt = SDC_S_GAP;
                  end
                  SDC_OP_PRE: begin
                     pins_nxt = drive(1'b1, SDC_CMD_PRECHARGE, req.ba, req.addr, 2'h0);
                     open_nxt = req.addr[`SDC_A10_BIT] ? 4'h0 : after_access(open_r, req.ba, 1'b1);
                  end
                  SDC_OP_STOP: if (burst_r) begin
                     pins_nxt = drive(1'b1, SDC_CMD_BURST_STOP, 2'h0, 13'h0_000, 2'h0);
                     burst_nxt = 1'b0;
                  end
                  // refresh and sleep only with every bank idle, otherwise a no-op
                  SDC_OP_REFRESH: if (open_r == 4'h0) begin
                     pins_nxt = drive(1'b1, SDC_CMD_REFRESH, 2'h0, 13'h0_000, 2'h3);
                     cnt_nxt = `SDC_CNT_W'(`SDC_REFRESH_CYCLE_TIME_CYC);
                     refs_nxt = 2'(`SDC_INIT_REFRESHES);
                     burst_nxt = 1'b0;
                     rdy_nxt = 1'b0;
                     st_nxt = SDC_S_REF;
                  end
                  SDC_OP_SELF: if (open_r == 4'h0) begin
                     pins_nxt = drive(1'b0, SDC_CMD_REFRESH, 2'h0, 13'h0_000, 2'h3);
                     burst_nxt = 1'b0;
                     rdy_nxt = 1'b0;
                     st_nxt = SDC_S_SELF;
                  end
                  SDC_OP_PDOWN: if (open_r == 4'h0) begin
                     pins_nxt = drive(1'b0, SDC_CMD_NOP, 2'h0, 13'h0_000, 2'h3);
                     rdy_nxt = 1'b0;
                     st_nxt = SDC_S_PDOWN;
                  end
                  default: pins_nxt = drive(1'b1, SDC_CMD_NOP, 2'h0, 13'h0_000, 2'h0);
               endcase
            end
         end
         SDC_S_PDOWN: begin
            pins_nxt = drive(wake, SDC_CMD_NOP, 2'h0, 13'h0_000, 2'h3);
            if (wake) begin
               cnt_nxt = `SDC_CNT_W'(1);
               st_nxt = SDC_S_GAP;
            end
         end
         SDC_S_SELF: begin
            pins_nxt = drive(wake, SDC_CMD_NOP, 2'h0, 13'h0_000, 2'h3);
            if (wake) begin
               cnt_nxt = `SDC_CNT_W'(`SDC_SELF_REFRESH_EXIT_DELAY_CYC);
               st_nxt = SDC_S_XSR;
            end
         end
         SDC_S_XSR: begin
            pins_nxt = drive(1'b1, SDC_CMD_NOP, 2'h0, 13'h0_000, 2'h3);
            if (cnt_r == '0) begin
               rdy_nxt = 1'b1;
               st_nxt = SDC_S_READY;
            end
         end
         default: st_nxt = SDC_S_WAIT;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_r <= SDC_S_WAIT;
         cnt_r <= `SDC_CNT_W'(`SDC_INIT_CYC);
         refs_r <= 2'd0;
         burst_r <= 1'b0;
         open_r <= 4'h0;
         pend_r <= '0;
         pins_r <= {1'b0, 4'h8, 2'h0, 13'h0_000, 2'h3};
         rdy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         refs_r <= refs_nxt;
         burst_r <= burst_nxt;
         open_r <= open_nxt;
         pend_r <= pend_nxt;
         pins_r <= pins_nxt;
         rdy_r <= rdy_nxt;
         done_r <= done_nxt;
      end
   end

   assign pins = pins_r;
   assign req_ready = rdy_r;
   assign init_done = done_r;

   // ****************************************
   // checks
   // ****************************************
   sequence gap_s;
      !pins_r.cke ##1 pins_r.cke;
   endsequence
   init_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r == SDC_S_WAIT) |-> (pins_r.cs_n == 1'b1)) else $error("command during power-up wait");
   mode_bank_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ({pins_r.cs_n, pins_r.ras_n, pins_r.cas_n, pins_r.we_n} == 4'h0) |-> (pins_r.ba == 2'h0 && pins_r.dqm == 2'h3))
      else $error("mode load with bad bank or bus");
   pre_gap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r == SDC_S_PRE && $past(st_r) == SDC_S_WAIT) |-> (pins_r.addr[`SDC_A10_BIT] && !pins_r.ras_n))
      else $error("precharge all missing");
   ref_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r == SDC_S_REF && cnt_r != '0) |-> ##1 (pins_r.ras_n && pins_r.cas_n)) else $error("command inside refresh");
   xsr_nops_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r == SDC_S_SELF && wake) |=> (pins_r.cke && pins_r.ras_n) [*2]) else $error("self refresh exit too busy");
   wake_rdy_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r == SDC_S_PDOWN && wake) |=> gap_s or (pins_r.cke ##2 rdy_r)) else $error("power-down exit late");
   write_mask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ({pins_r.cs_n, pins_r.ras_n, pins_r.cas_n, pins_r.we_n} == 4'h4)
      |-> ($past(pins_r.dqm) == 2'h3 && $past(pins_r.dqm, 2) == 2'h3))
      else $error("mask not raised ahead of write");
   stop_burst_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ({pins_r.cs_n, pins_r.ras_n, pins_r.cas_n, pins_r.we_n} == 4'h6) |-> $past(burst_r)) else $error("stop without burst");
   cke_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r == SDC_S_WAIT && cnt_r > `SDC_CNT_W'(`SDC_CKE_RAISE_CYC) + 1'b1) |-> !pins_r.cke)
      else $error("clock gate raised early");
   idle_cmd_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ({pins_r.cs_n, pins_r.ras_n, pins_r.cas_n} == 3'h0) |-> ($past(open_r) == 4'h0))
      else $error("refresh or mode load with a bank open");
endmodule : sdc_host
`default_nettype wire

// ### rtl/sdc_defines.svh
// constants for the sdram host controller
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH
`define SDC_CLK_NS 5
`define SDC_INIT_WAIT_NS 100000
`define SDC_INIT_CYC ((`SDC_INIT_WAIT_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_CKE_RAISE_CYC (`SDC_INIT_CYC / 2)
`define SDC_PRECHARGE_PERIOD_NS 20
`define SDC_REFRESH_CYCLE_TIME_NS 66
`define SDC_MODE_LOAD_DELAY_CYC 2
`define SDC_SELF_REFRESH_EXIT_DELAY_NS 75
`define SDC_TRP_CYC ((`SDC_PRECHARGE_PERIOD_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_REFRESH_CYCLE_TIME_CYC ((`SDC_REFRESH_CYCLE_TIME_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_SELF_REFRESH_EXIT_DELAY_CYC ((`SDC_SELF_REFRESH_EXIT_DELAY_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_INIT_REFRESHES 2
`define SDC_MODE_VALUE 13'h0_032
`define SDC_A10_BIT 10
`define SDC_CNT_W 16
`endif

// ### rtl/sdc_pkg.sv
// types for the sdram host controller
package sdc_pkg;
   // {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      SDC_CMD_INHIBIT = 4'h8,
      SDC_CMD_NOP = 4'h7,
      SDC_CMD_ACTIVATE = 4'h3,
      SDC_CMD_READ = 4'h5,
      SDC_CMD_WRITE = 4'h4,
      SDC_CMD_PRECHARGE = 4'h2,
      SDC_CMD_BURST_STOP = 4'h6,
      SDC_CMD_REFRESH = 4'h1,
      SDC_CMD_MODE_LOAD = 4'h0
   } sdc_cmd_t;
   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] ba;
      logic [12:0] addr;
      logic [1:0] dqm;
   } sdc_pins_t;
   typedef struct packed {
      logic valid;
      logic [2:0] op;
      logic [1:0] ba;
      logic [12:0] addr;
   } sdc_req_t;
   localparam logic [2:0] SDC_OP_ACT = 3'h0;
   localparam logic [2:0] SDC_OP_READ = 3'h1;
   localparam logic [2:0] SDC_OP_WRITE = 3'h2;
   localparam logic [2:0] SDC_OP_PRE = 3'h3;
   localparam logic [2:0] SDC_OP_STOP = 3'h4;
   localparam logic [2:0] SDC_OP_REFRESH = 3'h5;
   localparam logic [2:0] SDC_OP_SELF = 3'h6;
   localparam logic [2:0] SDC_OP_PDOWN = 3'h7;
   typedef enum logic [8:0] {
      SDC_S_WAIT = 9'h001,
      SDC_S_PRE = 9'h002,
      SDC_S_REF = 9'h004,
      SDC_S_MODE = 9'h008,
      SDC_S_GAP = 9'h010,
      SDC_S_READY = 9'h020,
      SDC_S_PDOWN = 9'h040,
      SDC_S_SELF = 9'h080,
      SDC_S_XSR = 9'h100
   } sdc_state_t;
endpackage : sdc_pkg

// ### bench/sdc_dev_model.sv
// behavioural sdram device on the host controller pins
`timescale 1ns/1ps
`default_nettype none
module sdc_dev_model #(
   parameter int INIT_CYC = 20000,
   parameter int PRECHARGE_PERIOD = 4,
   parameter int REFRESH_CYCLE_TIME = 14,
   parameter int MODE_LOAD_DELAY = 2,
   parameter int SELF_REFRESH_EXIT_DELAY = 15
) (
   // clock
   input wire logic clk_sys,
   // sdram pins
   input wire sdc_pkg::sdc_pins_t pins,
   // misuse count
   output logic [15:0] fault_cnt
);
   import sdc_pkg::*;
   logic cke_q, mode_ok, in_self;
   logic [3:0] open_r, cmd;
   int up_cnt, quiet;
   initial begin
      {cke_q, mode_ok, in_self, open_r, up_cnt, quiet, fault_cnt} = '0;
   end
   assign cmd = pins.cs_n ? 4'h8 : {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
   task automatic flag;
      fault_cnt = fault_cnt + 16'h0001;
   endtask : flag
   always @(posedge clk_sys) begin
      up_cnt = up_cnt + 1;
      if (up_cnt == INIT_CYC && !pins.cke) flag();
      if (!cke_q && pins.cke && in_self) begin
         in_self = 1'b0;
         quiet = SELF_REFRESH_EXIT_DELAY - 1;
      end else if (cke_q && (cmd == 4'h8 || cmd == 4'h7)) begin
         if (quiet > 0) quiet = quiet - 1;
      end else if (cke_q) begin
         if (quiet > 0 || up_cnt < INIT_CYC) flag();
         case (cmd)
            SDC_CMD_ACTIVATE: begin
               if (open_r[pins.ba] || !mode_ok) flag();
               open_r[pins.ba] = 1'b1;
            end
            SDC_CMD_READ, SDC_CMD_WRITE: begin
               if (!open_r[pins.ba]) flag();
               if (pins.addr[10]) open_r[pins.ba] = 1'b0;
            end
            SDC_CMD_PRECHARGE: begin
               if (pins.addr[10]) quiet = PRECHARGE_PERIOD - 1;
               if (pins.addr[10]) open_r = 4'h0;
               else open_r[pins.ba] = 1'b0;
            end
            SDC_CMD_REFRESH: begin
               if (open_r != 4'h0) flag();
               quiet = REFRESH_CYCLE_TIME - 1;
               in_self = !pins.cke;
            end
            SDC_CMD_MODE_LOAD: begin
               if (open_r != 4'h0 || pins.ba != 2'h0) flag();
               mode_ok = 1'b1;
               quiet = MODE_LOAD_DELAY - 1;
            end
            SDC_CMD_BURST_STOP: ;
            default: flag();
         endcase
      end
      cke_q = pins.cke;
   end
endmodule : sdc_dev_model
`default_nettype wire

// ### bench/sdc_host_tb.sv
// self-checking bench for the sdram host controller
`timescale 1ns/1ps
`default_nettype none
module sdc_host_tb;
   import sdc_pkg::*;
   logic clk_sys, nrst, wake, req_ready, init_done;
   sdc_req_t req;
   sdc_pins_t pins;
   logic [15:0] fault_cnt;
   logic [20:0] expq[$];
   logic [20:0] e;
   logic [19:0] got;
   logic [31:0] seed;
   logic [1:0] b, o;
   logic [1:0] dq1, dq2;
   logic [12:0] row, col;
   int errors, tests_run, n;
   sdc_host DUT (.clk_sys(clk_sys), .nrst(nrst), .req(req), .wake(wake), .req_ready(req_ready),
      .init_done(init_done), .pins(pins));
   sdc_dev_model MDL (.clk_sys(clk_sys), .pins(pins), .fault_cnt(fault_cnt));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   function automatic logic [20:0] mk(input logic f, input logic k, input sdc_cmd_t c, input logic [1:0] ba,
      input logic [12:0] a);
      return {f, k, c, ba, a};
   endfunction : mk
   task automatic check(input logic [19:0] g, input logic [19:0] x);
      tests_run++;
      if (g !== x) begin
         errors++;
         $display("BAD t=%0t seen %h expected %h", $time, g, x);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   // ****************************************
   // command monitor
   // ****************************************
   always @(posedge clk_sys) begin
      got = {pins.cke, pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n, pins.ba, pins.addr};
      if (nrst && !pins.cs_n && got[17:15] != 3'h7) begin
         e = (expq.size() > 0) ? expq.pop_front() : 21'h0;
         if (e[20]) check(got, e[19:0]);
         else check({got[19:15], 15'h0}, {e[19:15], 15'h0});
      end
      if (nrst && got[18:15] == 4'h4) check({14'h0, dq2, dq1, pins.dqm}, 20'h0_003c);
      dq2 = dq1;
      dq1 = pins.dqm;
   end
   // ****************************************
   // drivers
   // ****************************************
   task automatic issue(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a, input logic [20:0] x);
      int k;
      k = 0;
      req <= {1'b1, op, ba, a};
      do begin
         @(posedge clk_sys);
         k++;
      end while (!req_ready && k < 200);
      if (k >= 200) begin
         errors++;
         tally_and_finish();
      end
      if (x != 21'h0) expq.push_back(x);
      req.valid <= 1'b0;
      @(posedge clk_sys);
   endtask : issue
   task automatic sleep(input logic [2:0] op);
      issue(op, 2'h0, 13'h0, (op == SDC_OP_SELF) ? mk(0, 0, SDC_CMD_REFRESH, 0, 0) : 21'h0);
      repeat (8) @(posedge clk_sys);
      check({19'h0, pins.cke}, 20'h0);
      wake <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (!req_ready && n < 100);
      wake <= 1'b0;
      check({19'h0, pins.cke}, 20'h1);
      if (n >= 100) tally_and_finish();
   endtask : sleep
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {errors, tests_run, nrst, wake} = '0;
      req = '0;
      seed = 32'h3707;
      expq.push_back(mk(0, 1, SDC_CMD_PRECHARGE, 0, 0));
      expq.push_back(mk(0, 1, SDC_CMD_MODE_LOAD, 0, 0));
      expq.push_back(mk(0, 1, SDC_CMD_REFRESH, 0, 0));
      expq.push_back(mk(0, 1, SDC_CMD_REFRESH, 0, 0));
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (init_done !== 1'b1 && n < 30000);
      check({19'h0, init_done}, 20'h1);
      if (init_done !== 1'b1) tally_and_finish();
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         b = seed[1:0];
         o = b + 2'h1;
         row = seed[20:8];
         col = {3'h0, seed[31:22]};
         issue(SDC_OP_ACT, b, row, mk(1, 1, SDC_CMD_ACTIVATE, b, row));
         issue(SDC_OP_ACT, o, ~row, mk(1, 1, SDC_CMD_ACTIVATE, o, ~row));
         issue(SDC_OP_READ, b, col, mk(1, 1, SDC_CMD_READ, b, col));
         issue(SDC_OP_WRITE, o, col, mk(1, 1, SDC_CMD_WRITE, o, col));
         issue(SDC_OP_READ, b, col | 13'h0400, mk(1, 1, SDC_CMD_READ, b, col | 13'h0400));
         issue(SDC_OP_STOP, b, 13'h0, mk(0, 1, SDC_CMD_BURST_STOP, 0, 0));
         issue(SDC_OP_WRITE, o, col | 13'h0400, mk(1, 1, SDC_CMD_WRITE, o, col | 13'h0400));
      end
      issue(SDC_OP_ACT, 2'h0, row, mk(1, 1, SDC_CMD_ACTIVATE, 2'h0, row));
      issue(SDC_OP_ACT, 2'h1, row, mk(1, 1, SDC_CMD_ACTIVATE, 2'h1, row));
      issue(SDC_OP_WRITE, 2'h0, 13'h0400, mk(1, 1, SDC_CMD_WRITE, 2'h0, 13'h0400));
      issue(SDC_OP_READ, 2'h1, 13'h0400, mk(1, 1, SDC_CMD_READ, 2'h1, 13'h0400));
      issue(SDC_OP_REFRESH, 2'h0, 13'h0, mk(0, 1, SDC_CMD_REFRESH, 0, 0));
      issue(SDC_OP_STOP, 2'h0, 13'h0, 21'h0);
      sleep(SDC_OP_SELF);
      sleep(SDC_OP_PDOWN);
      issue(SDC_OP_PRE, 2'h0, 13'h0400, mk(0, 1, SDC_CMD_PRECHARGE, 0, 0));
      repeat (10) @(posedge clk_sys);
      check(20'(expq.size()), 20'h0);
      check({4'h0, fault_cnt}, 20'h0);
      tally_and_finish();
   end
   initial begin
      #400000;
      errors++;
      tally_and_finish();
   end
endmodule : sdc_host_tb
`default_nettype wire
